// file: substrate_shutter_sequencer.sv
// Top of the substrate shutter sequencer: registers, line counting and output gating.
// ----------------------------------------------------------------
// Notes on behaviour
// - Exposure counter holds pulses for programmed fields.
// - Sync-disable bit stops sync outputs during exposure.
// - Exposure trigger starts at next vertical sync.
// - Zero exposure count behaves like normal shuttering.
// - Pulsing starts line after the gate line.
// - Suppress count withholds first pulses after gate.
// - Gate and substrate pulses every field by default.
// - Readout count extends suppression after exposure.
// - Readout suppression only after readout trigger.
// - Both bits run exposure then readout automatically.
// - Readout alone starts at next vertical sync.
// - Trigger bits: shutters, bias, exposure, readout.
// - Mask modes: none, from next sync, fourth shutter.
// - Pulse starts at polarity, toggles at two positions.
// - High precision adds second pulse on last line.
// - Pulses per field follow twelve-bit count.
// - Settings latch at line after gate line.
// - All-ones second toggles disable extra pulse.
// ----------------------------------------------------------------
`timescale 1ns/100ps
module substrate_shutter_sequencer
  import shutter_pkg::*;
(
  input  wire logic         CORE_CLK,
  input  wire logic         RST,
  input  wire line_timing_t TIMING,
  input  wire logic         GATE_PULSE_IN,
  input  wire logic         FOURTH_SHUTTER_PULSE,
  input  wire logic         CFG_WRITE,
  input  wire logic [7:0]   CFG_ADDR,
  input  wire logic [11:0]  CFG_DATA,
  input  wire logic         TRIGGER_WRITE,
  input  wire logic [7:0]   TRIGGER_DATA,
  input  wire logic [2:0]   READOUT_FIELD_COUNT,
  input  wire logic         SYNC_OUTPUT_DISABLE,
  input  wire pulse_cfg_t   PULSE_SETTINGS,
  output logic              SUBSTRATE_CLEAR_PULSE,
  output logic              SENSOR_GATE_PULSE,
  output logic              VERTICAL_SYNC,
  output logic              HORIZONTAL_SYNC,
  output logic [5:0]        SHUTTER_TRIGGERS,
  output logic [11:0]       EXPOSURE_FIELD_COUNT,
  output logic [1:0]        SEQUENCE_PHASE
);

  // ----------------------------------------------------------------
  // Registers with printed addresses
  // ----------------------------------------------------------------
  logic [11:0] exposure_field_count;
  logic [11:0] next_exposure_field_count;
  logic [11:0] pulses_per_field;
  logic [11:0] next_pulses_per_field;
  mask_mode_t  extra_mask_mode;
  mask_mode_t  next_extra_mask_mode;
  logic [7:0]  operation_trigger;
  logic [7:0]  next_operation_trigger;

  always_comb begin
    next_exposure_field_count = exposure_field_count;
    next_pulses_per_field     = pulses_per_field;
    next_extra_mask_mode      = extra_mask_mode;
    next_operation_trigger    = TRIGGER_WRITE ? TRIGGER_DATA : 8'h00;
    if (CFG_WRITE) begin
      unique case (CFG_ADDR)
        EXPOSURE_FIELD_COUNT_OFS: next_exposure_field_count = CFG_DATA;
        PULSES_PER_FIELD_OFS:     next_pulses_per_field     = CFG_DATA;
        EXTRA_MASK_MODE_OFS:      next_extra_mask_mode      = mask_mode_t'(CFG_DATA[1:0]);
        default: ;
      endcase
    end
  end

  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      exposure_field_count <= ZERO12;
      pulses_per_field     <= PULSES_PER_FIELD_RST;
      extra_mask_mode      <= MASK_NONE;
      operation_trigger    <= 8'h00;
    end else begin
      exposure_field_count <= next_exposure_field_count;
      pulses_per_field     <= next_pulses_per_field;
      extra_mask_mode      <= next_extra_mask_mode;
      operation_trigger    <= next_operation_trigger;
    end
  end

  // Shutter and bias trigger bits go to the shutter logic as one-cycle pulses.
  assign SHUTTER_TRIGGERS     = operation_trigger[TRIG_BIAS_LSB+1:TRIG_SHUT_LSB];
  assign EXPOSURE_FIELD_COUNT = exposure_field_count;

  // ----------------------------------------------------------------
  // Field sequencing
  // ----------------------------------------------------------------
  logic   vs_prev;
  logic   hs_prev;
  logic   field_edge;
  logic   line_edge;
  phase_t phase;
  logic   exposure_suppress;

  assign field_edge = TIMING.vertical_sync & ~vs_prev;
  assign line_edge  = TIMING.horizontal_sync & ~hs_prev;

  field_sequencer #(
    .EXP_W (12),
    .RD_W  (3)
  ) u_field_sequencer (
    .clk               (CORE_CLK),
    .rst               (RST),
    .field_edge        (field_edge),
    .trig_exposure     (operation_trigger[TRIG_EXPOSURE]),
    .trig_readout      (operation_trigger[TRIG_READOUT]),
    .exposure_count    (exposure_field_count),
    .readout_count     (READOUT_FIELD_COUNT),
    .phase             (phase),
    .exposure_suppress (exposure_suppress)
  );

  assign SEQUENCE_PHASE = phase;

  // ----------------------------------------------------------------
  // Line counting and settings latch
  // ----------------------------------------------------------------
  pulse_cfg_t  cfg;
  pulse_cfg_t  next_cfg;
  logic        after_gate;
  logic        next_after_gate;
  logic        gate_seen;
  logic        next_gate_seen;
  logic [11:0] line_count;
  logic [11:0] next_line_count;
  logic        mask_active;
  logic        next_mask_active;

  // Latching only on the post-gate line keeps a mid-field write from tearing a pulse train.
  always_comb begin
    next_cfg         = cfg;
    next_after_gate  = after_gate;
    next_gate_seen   = gate_seen;
    next_line_count  = line_count;
    next_mask_active = mask_active;
    if (field_edge) begin
      next_mask_active = (cfg.mask_mode == MASK_AT_SYNC);
    end
    if (TIMING.gate_line) begin
      next_gate_seen = 1'b1;
    end
    if (line_edge) begin
      if (gate_seen) begin
        next_cfg        = PULSE_SETTINGS;
        next_cfg.pulses_per_field = pulses_per_field;
        next_cfg.mask_mode        = extra_mask_mode;
        next_after_gate = 1'b1;
        next_gate_seen  = 1'b0;
        next_line_count = 12'h000;
      end else if (after_gate && line_count != 12'hFFF) begin
        next_line_count = line_count + 12'h001;
      end
    end
  end

  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      cfg         <= '{start_polarity: 1'b0, first_toggle_a: TOGGLE_DISABLED,
                       first_toggle_b: TOGGLE_DISABLED, second_toggle_a: TOGGLE_DISABLED,
                       second_toggle_b: TOGGLE_DISABLED, pulses_per_field: PULSES_PER_FIELD_RST,
                       suppress_count: ZERO12, mask_mode: MASK_NONE};
      after_gate  <= 1'b0;
      gate_seen   <= 1'b0;
      line_count  <= ZERO12;
      mask_active <= 1'b0;
      vs_prev     <= 1'b0;
      hs_prev     <= 1'b0;
    end else begin
      cfg         <= next_cfg;
      after_gate  <= next_after_gate;
      gate_seen   <= next_gate_seen;
      line_count  <= next_line_count;
      mask_active <= next_mask_active;
      vs_prev     <= TIMING.vertical_sync;
      hs_prev     <= TIMING.horizontal_sync;
    end
  end

  // ----------------------------------------------------------------
  // Pulse window and gating
  // ----------------------------------------------------------------
  logic line_in_field;
  logic line_suppressed;
  logic last_line;
  logic phase_suppress;
  logic mask_suppress;
  logic pulse_enable;
  logic pulse_level;
  logic gate_level;

  assign line_in_field   = after_gate && (line_count < cfg.pulses_per_field);
  assign line_suppressed = (line_count < cfg.suppress_count);
  assign last_line       = (line_count == cfg.pulses_per_field - 12'h001);
  assign phase_suppress  = exposure_suppress || (phase == PH_READOUT);
  assign mask_suppress   = mask_active
                           || (cfg.mask_mode == MASK_SHUT4 && FOURTH_SHUTTER_PULSE);
  assign pulse_enable    = line_in_field && !line_suppressed && !phase_suppress
                           && !mask_suppress;

  pulse_shaper u_pulse_shaper (
    .clk           (CORE_CLK),
    .rst           (RST),
    .line_start    (line_edge),
    .pixel         (TIMING.pixel),
    .enable        (pulse_enable),
    .second_enable (pulse_enable && last_line),
    .cfg           (cfg),
    .level         (pulse_level)
  );

  // Gate pulses are held off only while the exposure counter runs.
  assign gate_level = GATE_PULSE_IN && !exposure_suppress;

  // ----------------------------------------------------------------
  // Output registers
  // ----------------------------------------------------------------
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      SUBSTRATE_CLEAR_PULSE <= 1'b0;
      SENSOR_GATE_PULSE     <= 1'b0;
      VERTICAL_SYNC         <= 1'b0;
      HORIZONTAL_SYNC       <= 1'b0;
    end else begin
      SUBSTRATE_CLEAR_PULSE <= pulse_enable ? pulse_level : cfg.start_polarity;
      SENSOR_GATE_PULSE     <= gate_level;
      VERTICAL_SYNC         <= TIMING.vertical_sync
                               && !(SYNC_OUTPUT_DISABLE && exposure_suppress);
      HORIZONTAL_SYNC       <= TIMING.horizontal_sync
                               && !(SYNC_OUTPUT_DISABLE && exposure_suppress);
    end
  end

endmodule

// file: shutter_pkg.sv
// Package with constants, types and register layout of the substrate shutter sequencer.
package shutter_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] EXPOSURE_FIELD_COUNT_OFS = 8'h63;
  localparam logic [7:0] PULSES_PER_FIELD_OFS     = 8'h64;
  localparam logic [7:0] EXTRA_MASK_MODE_OFS      = 8'h65;

  // ----------------------------------------------------------------
  // Trigger register bit positions
  // ----------------------------------------------------------------
  localparam int TRIG_SHUT_LSB  = 0;
  localparam int TRIG_BIAS_LSB  = 4;
  localparam int TRIG_EXPOSURE  = 6;
  localparam int TRIG_READOUT   = 7;

  // ----------------------------------------------------------------
  // Reset values and limits
  // ----------------------------------------------------------------
  localparam logic [11:0] TOGGLE_DISABLED       = 12'hFFF;
  localparam logic [11:0] PULSES_PER_FIELD_RST  = 12'h001;
  localparam logic [11:0] ZERO12                = 12'h000;
  localparam logic [2:0]  ZERO3                 = 3'h0;

  // ----------------------------------------------------------------
  // Extra mask modes
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    MASK_NONE    = 2'b00,
    MASK_AT_SYNC = 2'b01,
    MASK_SHUT4   = 2'b10,
    MASK_RSVD    = 2'b11
  } mask_mode_t;

  // ----------------------------------------------------------------
  // Sequence phases
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    PH_IDLE     = 2'b00,
    PH_EXPOSURE = 2'b01,
    PH_READOUT  = 2'b10
  } phase_t;

  // Substrate pulse settings, latched at the line after the gate line.
  typedef struct packed {
    logic        start_polarity;
    logic [11:0] first_toggle_a;
    logic [11:0] first_toggle_b;
    logic [11:0] second_toggle_a;
    logic [11:0] second_toggle_b;
    logic [11:0] pulses_per_field;
    logic [11:0] suppress_count;
    mask_mode_t  mask_mode;
  } pulse_cfg_t;

  // Per-line timing inputs from the timing generator.
  typedef struct packed {
    logic        vertical_sync;
    logic        horizontal_sync;
    logic        gate_line;
    logic [11:0] pixel;
  } line_timing_t;

endpackage

// file: field_sequencer.sv
// Field counter sequencing exposure then readout phases on vertical sync edges.
`timescale 1ns/100ps
module field_sequencer
  import shutter_pkg::*;
#(
  parameter int EXP_W = 12,
  parameter int RD_W  = 3
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             field_edge,
  input  wire logic             trig_exposure,
  input  wire logic             trig_readout,
  input  wire logic [EXP_W-1:0] exposure_count,
  input  wire logic [RD_W-1:0]  readout_count,
  output phase_t                phase,
  output logic                  exposure_suppress
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  phase_t           next_phase;
  logic [EXP_W-1:0] count;
  logic [EXP_W-1:0] next_count;
  logic             pend_exp;
  logic             pend_rd;
  logic             next_pend_exp;
  logic             next_pend_rd;
  logic             chain_rd;
  logic             next_chain_rd;

  // Triggers wait for the next field edge; a trigger landing on the edge waits one more.
  always_comb begin
    next_phase    = phase;
    next_count    = count;
    next_pend_exp = pend_exp | trig_exposure;
    next_pend_rd  = pend_rd | trig_readout;
    next_chain_rd = chain_rd;
    if (field_edge) begin
      unique case (phase)
        PH_IDLE: begin
          if (pend_exp) begin
            next_phase    = PH_EXPOSURE;
            next_count    = '0;
            next_chain_rd = pend_rd;
            next_pend_exp = trig_exposure;
            next_pend_rd  = trig_readout;
          end else if (pend_rd) begin
            next_phase   = PH_READOUT;
            next_count   = EXP_W'(readout_count);
            next_pend_rd = trig_readout;
          end
        end
        PH_EXPOSURE: begin
          if (count >= exposure_count) begin
            if (chain_rd) begin
              next_phase = PH_READOUT;
              next_count = EXP_W'(readout_count);
            end else begin
              next_phase = PH_IDLE;
            end
            next_chain_rd = 1'b0;
          end else begin
            next_count = count + 1'b1;
          end
        end
        PH_READOUT: next_count = count - 1'b1;
        default: next_phase = PH_IDLE;
      endcase
      if (next_phase == PH_READOUT && next_count == '0) next_phase = PH_IDLE;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      phase    <= PH_IDLE;
      count    <= '0;
      pend_exp <= 1'b0;
      pend_rd  <= 1'b0;
      chain_rd <= 1'b0;
    end else begin
      phase    <= next_phase;
      count    <= next_count;
      pend_exp <= next_pend_exp;
      pend_rd  <= next_pend_rd;
      chain_rd <= next_chain_rd;
    end
  end

  // The first exposure field keeps its pulses, so a zero count is plain shuttering.
  assign exposure_suppress = (phase == PH_EXPOSURE) && (count != '0);

endmodule

// file: pulse_shaper.sv
// Per-line substrate pulse waveform from two pairs of pixel toggle positions.
`timescale 1ns/100ps
module pulse_shaper
  import shutter_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        line_start,
  input  wire logic [11:0] pixel,
  input  wire logic        enable,
  input  wire logic        second_enable,
  input  wire pulse_cfg_t  cfg,
  output logic             level
);

  // ----------------------------------------------------------------
  // Toggle logic
  // ----------------------------------------------------------------
  logic next_level;
  logic hit_first;
  logic hit_second;
  logic second_armed;

  // All-ones positions in both second toggles disable the extra pulse.
  assign second_armed = second_enable
                        && !(cfg.second_toggle_a == TOGGLE_DISABLED
                             && cfg.second_toggle_b == TOGGLE_DISABLED);
  assign hit_first    = enable && (pixel == cfg.first_toggle_a || pixel == cfg.first_toggle_b);
  assign hit_second   = second_armed
                        && (pixel == cfg.second_toggle_a || pixel == cfg.second_toggle_b);

  always_comb begin
    next_level = level;
    if (line_start) begin
      next_level = cfg.start_polarity;
    end else if (hit_first ^ hit_second) begin
      next_level = ~level;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      level <= 1'b0;
    end else begin
      level <= next_level;
    end
  end

endmodule

// file: shutter_checker.sv
// Port-level assertions for the substrate shutter sequencer.
`timescale 1ns/100ps
module shutter_checker
  import shutter_pkg::*;
(
  input wire logic         CORE_CLK,
  input wire logic         RST,
  input wire line_timing_t TIMING,
  input wire logic         GATE_PULSE_IN,
  input wire logic         CFG_WRITE,
  input wire logic [7:0]   CFG_ADDR,
  input wire logic [11:0]  CFG_DATA,
  input wire logic         TRIGGER_WRITE,
  input wire logic [7:0]   TRIGGER_DATA,
  input wire logic         SYNC_OUTPUT_DISABLE,
  input wire logic         SENSOR_GATE_PULSE,
  input wire logic         VERTICAL_SYNC,
  input wire logic         HORIZONTAL_SYNC,
  input wire logic [5:0]   SHUTTER_TRIGGERS,
  input wire logic [11:0]  EXPOSURE_FIELD_COUNT,
  input wire logic [1:0]   SEQUENCE_PHASE
);
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (RST);
  logic later;
  always_ff @(posedge CORE_CLK)
    later <= SEQUENCE_PHASE == 2'h1 && (later || $rose(TIMING.vertical_sync));

  property p_gate_idle;
    SEQUENCE_PHASE == 2'h0 && $past(SEQUENCE_PHASE) == 2'h0 && !$past(RST)
      |-> SENSOR_GATE_PULSE == $past(GATE_PULSE_IN);
  endproperty
  a_gate_idle: assert property (p_gate_idle) else $error("gate pulse not passed while idle");
  property p_gate_exp;
    later && $past(later) |-> !SENSOR_GATE_PULSE;
  endproperty
  a_gate_exp: assert property (p_gate_exp) else $error("gate pulse during exposure");
  property p_sync_off;
    SYNC_OUTPUT_DISABLE && later && $past(later)
      |-> !VERTICAL_SYNC && !HORIZONTAL_SYNC;
  endproperty
  a_sync_off: assert property (p_sync_off) else $error("sync driven during exposure");
  property p_sync_on;
    !SYNC_OUTPUT_DISABLE && !$past(RST) |-> VERTICAL_SYNC == $past(TIMING.vertical_sync)
      && HORIZONTAL_SYNC == $past(TIMING.horizontal_sync);
  endproperty
  a_sync_on: assert property (p_sync_on) else $error("sync outputs not following");
  property p_start;
    $past(SEQUENCE_PHASE) == 2'h0 && SEQUENCE_PHASE != 2'h0 |-> $past(TIMING.vertical_sync)
      || $past(TIMING.vertical_sync, 2) || $past(TIMING.vertical_sync, 3);
  endproperty
  a_start: assert property (p_start) else $error("sequence started off vertical sync");
  property p_change;
    $past(SEQUENCE_PHASE) != SEQUENCE_PHASE |-> $past(TIMING.vertical_sync)
      || $past(TIMING.vertical_sync, 2) || $past(TIMING.vertical_sync, 3);
  endproperty
  a_change: assert property (p_change) else $error("phase moved off vertical sync");
  property p_trig;
    TRIGGER_WRITE |-> ##[1:2] SHUTTER_TRIGGERS == TRIGGER_DATA[5:0];
  endproperty
  a_trig: assert property (p_trig) else $error("shutter triggers not decoded");
  property p_trig_quiet;
    SHUTTER_TRIGGERS != 6'h00 |-> $past(TRIGGER_WRITE) || $past(TRIGGER_WRITE, 2);
  endproperty
  a_trig_quiet: assert property (p_trig_quiet) else $error("stray shutter trigger");
  property p_readback;
    CFG_WRITE && CFG_ADDR == EXPOSURE_FIELD_COUNT_OFS |-> ##[1:2] EXPOSURE_FIELD_COUNT == CFG_DATA;
  endproperty
  a_readback: assert property (p_readback) else $error("exposure count not stored");

  c_exposure: cover property (SEQUENCE_PHASE == 2'h1);
  c_readout: cover property (SEQUENCE_PHASE == 2'h2);
  c_sync_off: cover property (SYNC_OUTPUT_DISABLE && SEQUENCE_PHASE == 2'h1);
endmodule

bind substrate_shutter_sequencer shutter_checker chk (.CORE_CLK(CORE_CLK), .RST(RST),
  .TIMING(TIMING), .GATE_PULSE_IN(GATE_PULSE_IN), .CFG_WRITE(CFG_WRITE), .CFG_ADDR(CFG_ADDR),
  .CFG_DATA(CFG_DATA), .TRIGGER_WRITE(TRIGGER_WRITE), .TRIGGER_DATA(TRIGGER_DATA),
  .SYNC_OUTPUT_DISABLE(SYNC_OUTPUT_DISABLE), .SENSOR_GATE_PULSE(SENSOR_GATE_PULSE),
  .VERTICAL_SYNC(VERTICAL_SYNC), .HORIZONTAL_SYNC(HORIZONTAL_SYNC),
  .SHUTTER_TRIGGERS(SHUTTER_TRIGGERS), .EXPOSURE_FIELD_COUNT(EXPOSURE_FIELD_COUNT),
  .SEQUENCE_PHASE(SEQUENCE_PHASE));

// file: sensor_side_model.sv
// Sensor-side model that counts substrate clears and gate pulses in each field.
`timescale 1ns/100ps
module sensor_side_model (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        field_sync,
  input  wire logic        substrate,
  input  wire logic        gate,
  output logic [11:0]      clears,
  output logic [3:0]       gates
);
  logic [11:0] clear_run;
  logic [3:0]  gate_run;
  logic        sub_d;
  logic        gate_d;
  logic        sync_d;

  // Counts are frozen at each field start so the bench reads a whole field.
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      {clear_run, gate_run, sub_d, gate_d, sync_d, clears, gates} <= '0;
    end else begin
      sub_d <= substrate;
      gate_d <= gate;
      sync_d <= field_sync;
      if (field_sync && !sync_d) begin
        clears <= clear_run;
        gates <= gate_run;
        clear_run <= 12'h000;
        gate_run <= 4'h0;
      end else begin
        clear_run <= clear_run + 12'(substrate && !sub_d);
        gate_run <= gate_run + 4'(gate && !gate_d);
      end
    end
  end
endmodule

// file: substrate_shutter_sequencer_bench.sv
// Self-checking bench for the substrate shutter sequencer.
`timescale 1ns/100ps
module substrate_shutter_sequencer_bench
  import shutter_pkg::*;
;
  logic         clk       = 1'b0;
  logic         rst       = 1'b1;
  logic [3:0]   px        = 4'h0;
  logic [2:0]   ln        = 3'h0;
  line_timing_t timing;
  logic         gate_in;
  logic         fourth    = 1'b0;
  logic         cfg_wr    = 1'b0;
  logic [7:0]   cfg_addr  = 8'h00;
  logic [11:0]  cfg_data  = 12'h000;
  logic         trig_wr   = 1'b0;
  logic [7:0]   trig_data = 8'h00;
  logic [2:0]   rd_count  = 3'h0;
  logic         sync_off  = 1'b0;
  pulse_cfg_t   cfg       = '0;
  logic         sub_out, gate_out, vs_out, hs_out;
  logic [5:0]   shut;
  logic [11:0]  exp_rb, clears;
  logic [1:0]   phase;
  logic [3:0]   gates;
  int           n_fail    = 0;
  int           tests_run = 0;
  int           cycles    = 0;

  // ----------------------------------------------------------------
  // Timing source: 16-pixel lines, 8 lines a field, gate on line 1
  // ----------------------------------------------------------------
  assign timing = {ln == 3'h0 && px < 4'h4, px < 4'h2, ln == 3'h1, 8'h00, px};
  assign gate_in = ln == 3'h1 && px[3:1] == 3'h3;
  always #4 clk = ~clk;
  always @(negedge clk) begin
    px <= px + 4'h1;
    if (px == 4'hF) ln <= ln + 3'h1;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_fail++;
      summarize();
    end
  end

  substrate_shutter_sequencer dut (.CORE_CLK(clk), .RST(rst), .TIMING(timing),
    .GATE_PULSE_IN(gate_in), .FOURTH_SHUTTER_PULSE(fourth), .CFG_WRITE(cfg_wr),
    .CFG_ADDR(cfg_addr), .CFG_DATA(cfg_data), .TRIGGER_WRITE(trig_wr), .TRIGGER_DATA(trig_data),
    .READOUT_FIELD_COUNT(rd_count), .SYNC_OUTPUT_DISABLE(sync_off), .PULSE_SETTINGS(cfg),
    .SUBSTRATE_CLEAR_PULSE(sub_out), .SENSOR_GATE_PULSE(gate_out), .VERTICAL_SYNC(vs_out),
    .HORIZONTAL_SYNC(hs_out), .SHUTTER_TRIGGERS(shut), .EXPOSURE_FIELD_COUNT(exp_rb),
    .SEQUENCE_PHASE(phase));
  sensor_side_model sensor (.clk(clk), .rst(rst), .field_sync(timing.vertical_sync),
    .substrate(sub_out), .gate(gate_out), .clears(clears), .gates(gates));

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic [11:0] exp, input logic [11:0] got);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected %s: expected %0h, seen %0h", what, exp, got);
    end
  endtask
  task automatic cfg_write(input logic [7:0] a, input logic [11:0] d);
    @(negedge clk);
    cfg_addr = a;
    cfg_data = d;
    cfg_wr = 1'b1;
    @(negedge clk);
    cfg_wr = 1'b0;
  endtask
  task automatic trig(input logic [7:0] d);
    @(negedge clk);
    trig_data = d;
    trig_wr = 1'b1;
    @(negedge clk);
    trig_wr = 1'b0;
  endtask
  // Phase is sampled mid-field; counts belong to the field just closed.
  task automatic step(output logic [1:0] ph, output logic [11:0] s, output logic [3:0] g);
    repeat (60) @(negedge clk);
    ph = phase;
    @(posedge timing.vertical_sync);
    repeat (3) @(negedge clk);
    s = clears;
    g = gates;
  endtask
  task automatic settle(output logic [11:0] s);
    logic [1:0] ph;
    logic [3:0] g;
    step(ph, s, g);
    step(ph, s, g);
  endtask
  task automatic t_defaults;
    logic [1:0] ph;
    logic [11:0] s;
    logic [3:0] g;
    step(ph, s, g);
    step(ph, s, g);
    check("phase", 12'h000, {10'h000, ph});
    check("clears", 12'h001, s);
    check("gates", 12'h001, {8'h00, g});
    check("exposure readback", 12'h000, exp_rb);
    $display("end of defaults");
  endtask
  task automatic t_regs;
    cfg_write(EXPOSURE_FIELD_COUNT_OFS, 12'hFFF);
    @(negedge clk);
    check("exposure readback", 12'hFFF, exp_rb);
    cfg_write(8'h66, 12'h123);
    @(negedge clk);
    check("exposure readback", 12'hFFF, exp_rb);
    $display("end of registers");
  endtask
  task automatic t_counts;
    logic [11:0] s;
    logic [11:0] tab [4][3] = '{'{12'h005, 12'h002, 12'h003}, '{12'h006, 12'h000, 12'h006},
                                '{12'h002, 12'h002, 12'h000}, '{12'h003, 12'h000, 12'h003}};
    foreach (tab[i]) begin
      cfg_write(PULSES_PER_FIELD_OFS, tab[i][0]);
      cfg.suppress_count = tab[i][1];
      settle(s);
      check("clears", tab[i][2], s);
    end
    cfg.second_toggle_a = 12'h00A;
    cfg.second_toggle_b = 12'h00C;
    settle(s);
    check("clears", 12'h004, s);
    cfg.second_toggle_a = TOGGLE_DISABLED;
    cfg.second_toggle_b = TOGGLE_DISABLED;
    settle(s);
    check("clears", 12'h003, s);
    $display("end of counts");
  endtask
  task automatic t_triggers;
    logic [5:0] seen;
    logic [1:0] ph;
    logic [11:0] s;
    logic [3:0] g;
    for (int i = 0; i < 6; i++) begin
      trig(8'(1 << i));
      seen = shut;
      repeat (2) begin
        @(negedge clk);
        seen |= shut;
      end
      check("shutter triggers", 12'(1 << i), {6'h00, seen});
    end
    settle(s);
    step(ph, s, g);
    check("phase", 12'h000, {10'h000, ph});
    $display("end of triggers");
  endtask
  task automatic t_masks;
    logic [11:0] s;
    logic [11:0] tab [6][3] = '{'{12'h001, 12'h000, 12'h000}, '{12'h000, 12'h000, 12'h003},
      '{12'h002, 12'h001, 12'h000}, '{12'h002, 12'h000, 12'h003}, '{12'h003, 12'h000, 12'h003},
      '{12'h000, 12'h000, 12'h003}};
    foreach (tab[i]) begin
      fourth = tab[i][1][0];
      cfg_write(EXTRA_MASK_MODE_OFS, tab[i][0]);
      settle(s);
      check("clears", tab[i][2], s);
    end
    $display("end of masks");
  endtask
  task automatic t_exposure(input logic [11:0] n, input logic [2:0] r, input logic [7:0] d,
                            input logic off, input logic [11:0] e1, input logic [11:0] e2);
    logic [1:0] ph;
    logic [11:0] s, n1, n2;
    logic [3:0] g;
    rd_count = r;
    sync_off = off;
    cfg_write(EXPOSURE_FIELD_COUNT_OFS, n);
    trig(d);
    n1 = 12'h000;
    n2 = 12'h000;
    repeat (8) begin
      step(ph, s, g);
      if (ph === 2'h1) begin
        if (n1 == 0) check("clears", 12'h003, s);
        if (n1 != 0) check("clears", 12'h000, s);
        check("gates", {11'h000, n1 == 0}, {8'h00, g});
        n1++;
      end
      if (ph === 2'h2) begin
        check("clears", 12'h000, s);
        n2++;
      end
    end
    check("exposure fields", e1, n1);
    check("readout fields", e2, n2);
    sync_off = 1'b0;
    $display("end of exposure");
  endtask
  task automatic summarize;
    $display("comparisons %0d, mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  initial begin
    cfg.first_toggle_a = 12'h004;
    cfg.first_toggle_b = 12'h008;
    cfg.second_toggle_a = TOGGLE_DISABLED;
    cfg.second_toggle_b = TOGGLE_DISABLED;
    repeat (4) @(negedge clk);
    rst = 1'b0;
    t_defaults();
    t_regs();
    t_counts();
    t_triggers();
    t_masks();
    t_exposure(12'h002, 3'h1, 8'hC0, 1'b1, 12'h003, 12'h001);
    t_exposure(12'h000, 3'h1, 8'h40, 1'b0, 12'h001, 12'h000);
    t_exposure(12'h000, 3'h2, 8'h80, 1'b0, 12'h000, 12'h002);
    summarize();
  end
endmodule
